/* rtl/urc_redriver_ctrl.sv */
`timescale 1ns/1ps
// Notes on behaviour
// (RQ1) Strap mode: gains come from straps only; connector gains follow aeq_result while aeq_pin is high
// (RQ2) Config high/resistor: system gains from own strap
// (RQ3) Config low/float: system straps form 16-way selector
// (RQ4) Config low/resistor: connector gains from own strap
// (RQ5) Config float/high: connector straps form 16-way selector
// (RQ6) Path enabled: exactly one of four states
// (RQ7) Disconnect until both terminations, then U0
// (RQ8) U0 forwards traffic both directions
// (RQ9) Both sides idle in U0: go U1
// (RQ10) U1 keeps terminations and common mode
// (RQ11) U2/U3 periodically detects, watches LFPS
// (RQ12) Lost termination in U2/U3: go Disconnect
// (RQ13) Valid LFPS in U2/U3: go U0
// (RQ14) U2/U3 keeps terminations, drops common mode
// (RQ15) Low power disable field blocks U1, U2
// (RQ16) Strap mode keeps U1, U2 available
// (RQ17) Control writes pick path, orientation, override
// (RQ18) Control bit 7 selects limited mode
// (RQ19) Adaptive control: off, fast or full
// (RQ20) Long and short connector registers, fast picks
// (RQ21) Full adaptation ignores short channel register
// (RQ22) System eq, swing and over-eq registers
// (RQ23) Limited-mode transmitter eq registers
// (RQ24) Fixed connector registers need override set
// (RQ25) Mode strap: float serial, high strap
// (RQ26) U1 resumes to U0 or idles to U2/U3
// (RQ27) Straps sampled once after reset
module urc_redriver_ctrl (
  input wire logic clk_sys, // 20 MHz system clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [1:0] mode_strap, // Config mode strap level
  input wire logic [1:0] eq_config_strap, // Eq config strap level
  input wire logic [1:0] sys_gain_strap_0, // System gain strap 0
  input wire logic [1:0] sys_gain_strap_1, // System gain strap 1
  input wire logic [1:0] conn_gain_strap_0, // Connector gain strap 0
  input wire logic [1:0] conn_gain_strap_1, // Connector gain strap 1
  input wire logic path_en_pin, // Path enable pin, strap mode
  input wire logic flip_pin, // Orientation pin, strap mode
  input wire logic aeq_pin, // Full adaptation pin, strap mode
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  input wire logic [7:0] reg_addr, // Register offset
  input wire logic [7:0] reg_wdata, // Register write data
  input wire logic rxdet_done, // Detection result valid pulse
  input wire logic term_ufp, // Far-end termination, upstream
  input wire logic term_dfp, // Far-end termination, downstream
  input wire logic eidle_ufp, // Electrical idle, upstream
  input wire logic eidle_dfp, // Electrical idle, downstream
  input wire logic lfps_valid, // Valid LFPS seen
  input wire logic chan_long, // Fast adaptation says long channel
  input wire logic [3:0] aeq_result, // Full adaptation gain result
  output logic [7:0] reg_rdata, // Read data, one cycle after strobe
  output urc_pkg::urc_link_e link_state, // Link power state
  output logic fwd_en, // Redrive traffic
  output logic rx_term_en, // Receiver terminations on
  output logic tx_cm_hold, // Transmitter common mode held
  output logic rxdet_start, // Start far-end detection pulse
  output logic [3:0] sys_eq_1, // System-side receiver 1 gain
  output logic [3:0] sys_eq_2, // System-side receiver 2 gain
  output logic [3:0] conn_eq_1, // Connector-side receiver 1 gain
  output logic [3:0] conn_eq_2, // Connector-side receiver 2 gain
  output logic [1:0] aeq_mode, // Adaptation mode
  output logic [3:0] aeq_limit, // Full adaptation upper limit
  output logic [7:0] over_eq, // Over-eq adjustment
  output logic [7:0] swing, // Output swing control
  output logic limited_mode, // Limited redriver mode
  output logic [7:0] tx1_eq, // Transmitter 1 preshoot/de-emph
  output logic [7:0] tx2_eq, // Transmitter 2 preshoot/de-emph
  output logic flip // Orientation
);
  import urc_pkg::*;

  // Single-strap level to gain code
  function automatic logic [3:0] f_gain(input logic [1:0] lvl);
    logic [3:0] g;
    g = GAIN_3DB;
    unique case (lvl)
      LVL_LOW: g = GAIN_3DB;
      LVL_RES: g = GAIN_6DB;
      LVL_FLT: g = GAIN_9DB;
      LVL_HIGH: g = GAIN_12DB;
    endcase
    return g;
  endfunction

  // Captured straps
  logic strap_done_reg; // Straps captured
  logic strap_mode_reg; // Strap mode rather than serial
  logic [1:0] cfg_reg; // Eq config level
  logic [1:0] ss0_reg, ss1_reg; // System gain levels
  logic [1:0] cs0_reg, cs1_reg; // Connector gain levels

  // Register file
  logic [7:0] gen_ctrl_reg, tx1_reg, tx2_reg, aeq_ctrl_reg;
  logic [7:0] over_eq_reg, long_reg, short_reg, sys_eq_reg, swing_reg;

  // Link state and timer
  urc_link_e state_reg, state_next; // Link power state
  logic [TMR_W-1:0] tmr_reg, tmr_next; // Detect or idle timer

  // Output flops
  logic fwd_reg, term_reg, cm_reg, det_reg;
  logic [3:0] seq1_reg, seq2_reg, conn_gain_strap_1_reg, ceq2_reg, lim_reg;
  logic [1:0] amode_reg;
  logic [7:0] over_reg, swo_reg, t1o_reg, t2o_reg, rdata_reg;
  logic limo_reg, flip_reg;

  // Derived controls
  wire path_en_w; // Path enabled
  wire lp_dis_w; // Low power states suppressed
  wire both_term_w; // Termination on both sides
  wire both_idle_w; // Idle on both sides
  wire det_ok_w; // Detection found both
  wire det_fail_w; // Detection lost a side
  wire tmr_hit_w; // Timer at its limit
  wire sys_split_w; // System straps used singly
  wire conn_split_w; // Connector straps used singly
  wire eq_ovr_w; // Override set
  wire aeq_on_w, aeq_full_w; // Adaptation flags
  wire [3:0] combo_sys_w, combo_conn_w; // 16-way selectors
  wire [3:0] full_gain_w; // Clamped full result
  wire [3:0] fixed_conn_w; // Fast/fixed register pick
  wire [3:0] s1_next, s2_next, c1_next, c2_next;
  wire [7:0] rd_mux_w; // Read data select

  // (RQ25) mode strap choice
  wire strap_mode_w = (mode_strap != LVL_FLT);

  // (RQ17) path, flip and override fields
  assign path_en_w = strap_mode_reg ? path_en_pin : gen_ctrl_reg[GC_PATH_EN];
  assign eq_ovr_w = gen_ctrl_reg[GC_EQ_OVR];
  // (RQ15) (RQ16) suppression only in serial mode
  assign lp_dis_w = !strap_mode_reg && gen_ctrl_reg[GC_LP_DIS];
  assign both_term_w = term_ufp && term_dfp;
  assign both_idle_w = eidle_ufp && eidle_dfp;
  assign det_ok_w = rxdet_done && both_term_w;
  assign det_fail_w = rxdet_done && !both_term_w;

  // (RQ2) (RQ4) single-strap level choices
  assign sys_split_w = (cfg_reg == LVL_HIGH) || (cfg_reg == LVL_RES);
  assign conn_split_w = (cfg_reg == LVL_LOW) || (cfg_reg == LVL_RES);
  // (RQ3) (RQ5) both straps form one selector
  assign combo_sys_w = {ss1_reg, ss0_reg};
  assign combo_conn_w = {cs1_reg, cs0_reg};

  // (RQ19) adaptation decode
  assign aeq_on_w = aeq_ctrl_reg[AEQ_EN];
  assign aeq_full_w = aeq_on_w && aeq_ctrl_reg[AEQ_FULL];
  assign full_gain_w = (aeq_result > aeq_ctrl_reg[7:AEQ_LIM_LSB]) ?
                       aeq_ctrl_reg[7:AEQ_LIM_LSB] : aeq_result;
  // (RQ20) fast picks long or short register
  assign fixed_conn_w = (aeq_on_w && chan_long) ? long_reg[3:0] :
                        short_reg[3:0];

  // (RQ1) strap mode uses straps alone
  assign s1_next = strap_mode_reg ?
                   (sys_split_w ? f_gain(ss0_reg) : combo_sys_w) :
                   sys_eq_reg[3:0];
  // (RQ22) system register sets both receivers
  assign s2_next = strap_mode_reg ?
                   (sys_split_w ? f_gain(ss1_reg) : combo_sys_w) :
                   sys_eq_reg[7:4];
  // (RQ21) (RQ24) full ignores short; fixed needs override
  assign c1_next = strap_mode_reg ?
      (aeq_pin ? aeq_result :
       (conn_split_w ? f_gain(cs0_reg) : combo_conn_w)) :
      (aeq_full_w ? full_gain_w :
       (eq_ovr_w ? fixed_conn_w :
        (conn_split_w ? f_gain(cs0_reg) : combo_conn_w)));
  assign c2_next = strap_mode_reg ?
      (aeq_pin ? aeq_result :
       (conn_split_w ? f_gain(cs1_reg) : combo_conn_w)) :
      (aeq_full_w ? full_gain_w :
       (eq_ovr_w ? fixed_conn_w :
        (conn_split_w ? f_gain(cs1_reg) : combo_conn_w)));

  // Read data select, unmapped reads zero
  assign rd_mux_w = (reg_addr == OFS_GEN_CTRL) ? gen_ctrl_reg :
                    (reg_addr == OFS_TX1_LIM_EQ) ? tx1_reg :
                    (reg_addr == OFS_TX2_LIM_EQ) ? tx2_reg :
                    (reg_addr == OFS_AEQ_CTRL) ? aeq_ctrl_reg :
                    (reg_addr == OFS_OVER_EQ) ? over_eq_reg :
                    (reg_addr == OFS_CONN_LONG) ? long_reg :
                    (reg_addr == OFS_CONN_SHORT) ? short_reg :
                    (reg_addr == OFS_SYS_EQ) ? sys_eq_reg :
                    (reg_addr == OFS_SWING) ? swing_reg : 8'h00;

  assign tmr_hit_w = (state_reg == LS_U1) ?
                     (tmr_reg == TMR_W'(U1_IDLE_CYC - 1)) :
                     (tmr_reg == TMR_W'(RXDET_CYC - 1));

  // (RQ27) capture straps once after reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      strap_done_reg <= 1'b0;
      strap_mode_reg <= 1'b0;
      {cfg_reg, ss0_reg, ss1_reg, cs0_reg, cs1_reg} <= 10'h000;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      strap_mode_reg <= strap_mode_w;
      cfg_reg <= eq_config_strap;
      {ss1_reg, ss0_reg} <= {sys_gain_strap_1, sys_gain_strap_0};
      {cs1_reg, cs0_reg} <= {conn_gain_strap_1, conn_gain_strap_0};
    end
  end

  // Register writes
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      gen_ctrl_reg <= RST_GEN_CTRL;
      aeq_ctrl_reg <= RST_AEQ_CTRL;
      {tx1_reg, tx2_reg, over_eq_reg} <= {3{RST_OTHER}};
      {long_reg, short_reg, sys_eq_reg, swing_reg} <= {4{RST_OTHER}};
    end else if (reg_wr) begin
      unique case (reg_addr)
        OFS_GEN_CTRL: gen_ctrl_reg <= reg_wdata;
        OFS_TX1_LIM_EQ: tx1_reg <= reg_wdata;
        OFS_TX2_LIM_EQ: tx2_reg <= reg_wdata;
        OFS_AEQ_CTRL: aeq_ctrl_reg <= reg_wdata;
        OFS_OVER_EQ: over_eq_reg <= reg_wdata;
        OFS_CONN_LONG: long_reg <= reg_wdata;
        OFS_CONN_SHORT: short_reg <= reg_wdata;
        OFS_SYS_EQ: sys_eq_reg <= reg_wdata;
        OFS_SWING: swing_reg <= reg_wdata;
        default: ; // Unmapped writes ignored
      endcase
    end
  end

  // (RQ6) link state next value
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      // (RQ7) wait for both terminations
      LS_DISC: if (det_ok_w) begin
        state_next = LS_U0;
      end
      // (RQ9) both idle moves to U1
      LS_U0: if (both_idle_w && !lp_dis_w) begin
        state_next = LS_U1;
      end
      // (RQ26) resume or sink deeper
      LS_U1: if (lfps_valid || !both_idle_w) begin
        state_next = LS_U0;
      end else if (tmr_hit_w) begin
        state_next = LS_U23;
      end
      // (RQ13) (RQ12) LFPS wins over lost termination
      LS_U23: if (lfps_valid) begin
        state_next = LS_U0;
      end else if (det_fail_w) begin
        state_next = LS_DISC;
      end
    endcase
    if (!path_en_w || !strap_done_reg) begin
      state_next = LS_DISC;
    end else if (lp_dis_w && state_next != LS_DISC) begin
      // (RQ15) no low power states when suppressed
      state_next = LS_U0;
    end
  end

  // Timer restarts on every state change
  always_comb begin
    tmr_next = '0;
    if (state_next == state_reg && state_next != LS_U0 && !tmr_hit_w) begin
      tmr_next = tmr_reg + TMR_W'(1);
    end
  end

  // State and timer flops
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= LS_DISC;
      tmr_reg <= '0;
    end else begin
      state_reg <= state_next;
      tmr_reg <= tmr_next;
    end
  end

  // Link side output flops
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      {fwd_reg, term_reg, cm_reg, det_reg} <= 4'h0;
    end else begin
      // (RQ8) forward only in U0
      fwd_reg <= (state_next == LS_U0);
      // (RQ10) (RQ14) terminations in U0, U1, U2/U3
      term_reg <= (state_next != LS_DISC);
      // (RQ10) (RQ14) common mode held in U0, U1 only
      cm_reg <= (state_next == LS_U0) || (state_next == LS_U1);
      // (RQ11) periodic detection in Disconnect and U2/U3
      det_reg <= path_en_w && tmr_hit_w && (state_reg == state_next) &&
                 ((state_reg == LS_DISC) || (state_reg == LS_U23));
    end
  end

  // Equalisation and transmitter output flops
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      {seq1_reg, seq2_reg, conn_gain_strap_1_reg, ceq2_reg, lim_reg} <= 20'h00000;
      amode_reg <= AEQ_MODE_OFF;
      {over_reg, swo_reg, t1o_reg, t2o_reg} <= 32'h00000000;
      {limo_reg, flip_reg} <= 2'h0;
    end else begin
      seq1_reg <= s1_next;
      seq2_reg <= s2_next;
      conn_gain_strap_1_reg <= c1_next;
      ceq2_reg <= c2_next;
      lim_reg <= aeq_ctrl_reg[7:AEQ_LIM_LSB];
      amode_reg <= strap_mode_reg ?
                   (aeq_pin ? AEQ_MODE_FULL : AEQ_MODE_OFF) :
                   (aeq_full_w ? AEQ_MODE_FULL :
                    (aeq_on_w ? AEQ_MODE_FAST : AEQ_MODE_OFF));
      // (RQ22) over-eq from register; swing from register in serial mode, SWING_STRAP in strap mode
      over_reg <= over_eq_reg;
      swo_reg <= strap_mode_reg ? SWING_STRAP : swing_reg;
      // (RQ18) bit 7 selects limited mode
      limo_reg <= !strap_mode_reg && gen_ctrl_reg[GC_LIMITED];
      // (RQ23) transmitter eq applies in limited mode
      t1o_reg <= (!strap_mode_reg && gen_ctrl_reg[GC_LIMITED]) ?
                 tx1_reg : 8'h00;
      t2o_reg <= (!strap_mode_reg && gen_ctrl_reg[GC_LIMITED]) ?
                 tx2_reg : 8'h00;
      // (RQ17) orientation from field or pin
      flip_reg <= strap_mode_reg ? flip_pin : gen_ctrl_reg[GC_FLIP];
    end
  end

  // Read data flop
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      rdata_reg <= rd_mux_w;
    end
  end

  assign reg_rdata = rdata_reg;
  assign link_state = state_reg;
  assign fwd_en = fwd_reg;
  assign rx_term_en = term_reg;
  assign tx_cm_hold = cm_reg;
  assign rxdet_start = det_reg;
  assign sys_eq_1 = seq1_reg;
  assign sys_eq_2 = seq2_reg;
  assign conn_eq_1 = conn_gain_strap_1_reg;
  assign conn_eq_2 = ceq2_reg;
  assign aeq_mode = amode_reg;
  assign aeq_limit = lim_reg;
  assign over_eq = over_reg;
  assign swing = swo_reg;
  assign limited_mode = limo_reg;
  assign tx1_eq = t1o_reg;
  assign tx2_eq = t2o_reg;
  assign flip = flip_reg;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_term_found;
    state_reg == LS_DISC && det_ok_w && path_en_w && strap_done_reg;
  endsequence
  sequence s_u0_entered;
    state_reg == LS_U0 ##0 fwd_en && tx_cm_hold && rx_term_en;
  endsequence

  property p_disc_to_u0;
    s_term_found |=> s_u0_entered;
  endproperty
  a_disc_to_u0: assert property (p_disc_to_u0) // RQ7
    else $error("Disconnect did not go to U0");

  property p_u0_to_u1;
    state_reg == LS_U0 && both_idle_w && path_en_w && !lp_dis_w
      |=> state_reg == LS_U1 && !fwd_en;
  endproperty
  a_u0_to_u1: assert property (p_u0_to_u1) // RQ9
    else $error("U0 did not go to U1 on idle");

  property p_lfps_wake;
    state_reg == LS_U23 && lfps_valid && path_en_w |=> s_u0_entered;
  endproperty
  a_lfps_wake: assert property (p_lfps_wake) // RQ13
    else $error("LFPS did not wake to U0");

  property p_lost_term;
    state_reg == LS_U23 && det_fail_w && !lfps_valid
      |=> state_reg == LS_DISC && !rx_term_en;
  endproperty
  a_lost_term: assert property (p_lost_term) // RQ12
    else $error("Lost termination kept U2/U3");

  property p_fwd_u0;
    fwd_en == (state_reg == LS_U0);
  endproperty
  a_fwd_u0: assert property (p_fwd_u0) // RQ8
    else $error("Forwarding does not match U0");

  property p_u1_hold;
    state_reg == LS_U1 |-> rx_term_en && tx_cm_hold;
  endproperty
  a_u1_hold: assert property (p_u1_hold) // RQ10
    else $error("U1 lost termination or common mode");

  property p_u23_hold;
    state_reg == LS_U23 |-> rx_term_en && !tx_cm_hold;
  endproperty
  a_u23_hold: assert property (p_u23_hold) // RQ14
    else $error("U2/U3 terminations or common mode wrong");

  property p_lp_dis;
    lp_dis_w [*2] |-> state_reg != LS_U1 && state_reg != LS_U23;
  endproperty
  a_lp_dis: assert property (p_lp_dis) // RQ15
    else $error("Low power state entered while disabled");

  property p_strap_sys;
    strap_done_reg && strap_mode_reg && sys_split_w
      |=> sys_eq_1 == f_gain(ss0_reg) && sys_eq_2 == f_gain(ss1_reg);
  endproperty
  a_strap_sys: assert property (p_strap_sys) // RQ2
    else $error("Strapped system gain wrong");
endmodule : urc_redriver_ctrl

/* rtl/urc_pkg.sv */
package urc_pkg;
  // Four-level strap codes as delivered by the pin sensors
  localparam logic [1:0] LVL_LOW = 2'h0; // Tied low
  localparam logic [1:0] LVL_RES = 2'h1; // Resistor pulled
  localparam logic [1:0] LVL_FLT = 2'h2; // Floating
  localparam logic [1:0] LVL_HIGH = 2'h3; // Tied high

  // Gain codes for single-strap settings
  localparam logic [3:0] GAIN_3DB = 4'h2; // 3 dB at 5 GHz
  localparam logic [3:0] GAIN_6DB = 4'h6; // 6 dB at 5 GHz
  localparam logic [3:0] GAIN_9DB = 4'hA; // 9 dB at 5 GHz
  localparam logic [3:0] GAIN_12DB = 4'hF; // 12 dB at 5 GHz

  // Register offsets
  localparam logic [7:0] OFS_GEN_CTRL = 8'h0A; // General control
  localparam logic [7:0] OFS_TX1_LIM_EQ = 8'h0B; // Transmitter 1 limited eq
  localparam logic [7:0] OFS_TX2_LIM_EQ = 8'h0C; // Transmitter 2 limited eq
  localparam logic [7:0] OFS_AEQ_CTRL = 8'h1C; // Adaptive eq control
  localparam logic [7:0] OFS_OVER_EQ = 8'h1D; // Over-eq adjustment
  localparam logic [7:0] OFS_CONN_LONG = 8'h1E; // Connector long channel
  localparam logic [7:0] OFS_CONN_SHORT = 8'h20; // Connector short channel
  localparam logic [7:0] OFS_SYS_EQ = 8'h21; // System-side receiver eq
  localparam logic [7:0] OFS_SWING = 8'h32; // Output swing

  // Reset values
  localparam logic [7:0] RST_GEN_CTRL = 8'h00; // Path off, linear
  localparam logic [7:0] RST_AEQ_CTRL = 8'h80; // Adaptation off
  localparam logic [7:0] RST_OTHER = 8'h00; // All other registers

  // General control fields
  localparam int GC_PATH_EN = 0; // Path enable
  localparam int GC_FLIP = 2; // Flipped orientation
  localparam int GC_LP_DIS = 3; // Low power disable
  localparam int GC_EQ_OVR = 4; // Equalisation override
  localparam int GC_LIMITED = 7; // Limited redriver mode

  // Adaptive control fields
  localparam int AEQ_EN = 0; // Adaptation enable
  localparam int AEQ_FULL = 2; // Full rather than fast
  localparam int AEQ_LIM_LSB = 4; // Upper eq limit, bits 7:4

  // Adaptation mode as driven out
  localparam logic [1:0] AEQ_MODE_OFF = 2'h0; // Fixed eq
  localparam logic [1:0] AEQ_MODE_FAST = 2'h1; // Fast
  localparam logic [1:0] AEQ_MODE_FULL = 2'h2; // Full

  // Swing code used while strapped: highest linearity
  localparam logic [7:0] SWING_STRAP = 8'hC0;

  // Timing
  localparam int CLK_PERIOD_NS = 50; // 20 MHz system clock
  localparam int RXDET_PERIOD_NS = 12000; // Receiver detection interval
  localparam int U1_IDLE_NS = 10000; // Idle time before U2/U3
  localparam int RXDET_CYC = RXDET_PERIOD_NS / CLK_PERIOD_NS;
  localparam int U1_IDLE_CYC = U1_IDLE_NS / CLK_PERIOD_NS;
  localparam int TMR_W = 9; // Width of the shared timer

  // Link power states
  typedef enum logic [1:0] {
    LS_DISC,
    LS_U0,
    LS_U1,
    LS_U23
  } urc_link_e;
endpackage : urc_pkg

/* dv/urc_far_end.sv */
`timescale 1ns/1ps
// Far-end model: answers detection requests
module urc_far_end (
  input wire logic clk_sys, // System clock
  input wire logic rxdet_start, // Detection request pulse
  input wire logic attach_ufp, // Upstream partner present
  input wire logic attach_dfp, // Downstream partner present
  input wire logic [3:0] resp_dly, // Answer delay in cycles
  output logic rxdet_done, // Result valid pulse
  output logic term_ufp, // Upstream termination seen
  output logic term_dfp // Downstream termination seen
);
  int cnt = 0; // Cycles left until answer
  initial begin
    rxdet_done = 1'b0;
    term_ufp = 1'b0;
    term_dfp = 1'b0;
  end
  // Results hold in the done cycle only, then invert
  always @(posedge clk_sys) begin
    #1;
    if (rxdet_done) begin
      rxdet_done = 1'b0;
      term_ufp = ~term_ufp;
      term_dfp = ~term_dfp;
    end
    if (cnt == 1) begin
      rxdet_done = 1'b1;
      term_ufp = attach_ufp;
      term_dfp = attach_dfp;
    end
    if (cnt > 0)
      cnt--;
    if (rxdet_start)
      cnt = resp_dly + 1;
  end
endmodule // urc_far_end

/* dv/test_usb_redriver_state_and_eq_ctrl.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module test_usb_redriver_state_and_eq_ctrl;
  import urc_pkg::*;
  logic clk_sys, rst_n, path_en_pin, flip_pin, aeq_pin, reg_wr, reg_rd;
  logic [1:0] mode_strap, eq_config_strap, sys_gain_strap_0;
  logic [1:0] sys_gain_strap_1, conn_gain_strap_0, conn_gain_strap_1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, over_eq, swing, tx1_eq, tx2_eq;
  logic [3:0] aeq_result, sys_eq_1, sys_eq_2, conn_eq_1, conn_eq_2;
  logic [3:0] aeq_limit, resp_dly;
  logic rxdet_done, term_ufp, term_dfp, eidle_ufp, eidle_dfp, lfps_valid;
  logic chan_long, fwd_en, rx_term_en, tx_cm_hold, rxdet_start;
  logic limited_mode, flip, attach_ufp, attach_dfp;
  logic [1:0] aeq_mode;
  urc_link_e link_state;
  int err_total = 0; // Mismatches
  int checks = 0; // Comparisons
  // Device under test
  urc_redriver_ctrl DUT (.clk_sys(clk_sys), .rst_n(rst_n),
    .mode_strap(mode_strap), .eq_config_strap(eq_config_strap),
    .sys_gain_strap_0(sys_gain_strap_0), .sys_gain_strap_1(sys_gain_strap_1),
    .conn_gain_strap_0(conn_gain_strap_0),
    .conn_gain_strap_1(conn_gain_strap_1), .path_en_pin(path_en_pin),
    .flip_pin(flip_pin), .aeq_pin(aeq_pin), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .rxdet_done(rxdet_done),
    .term_ufp(term_ufp), .term_dfp(term_dfp), .eidle_ufp(eidle_ufp),
    .eidle_dfp(eidle_dfp), .lfps_valid(lfps_valid), .chan_long(chan_long),
    .aeq_result(aeq_result), .reg_rdata(reg_rdata), .link_state(link_state),
    .fwd_en(fwd_en), .rx_term_en(rx_term_en), .tx_cm_hold(tx_cm_hold),
    .rxdet_start(rxdet_start), .sys_eq_1(sys_eq_1), .sys_eq_2(sys_eq_2),
    .conn_eq_1(conn_eq_1), .conn_eq_2(conn_eq_2), .aeq_mode(aeq_mode),
    .aeq_limit(aeq_limit), .over_eq(over_eq), .swing(swing),
    .limited_mode(limited_mode), .tx1_eq(tx1_eq), .tx2_eq(tx2_eq),
    .flip(flip));
  // Far side of the link
  urc_far_end far_end (.clk_sys(clk_sys), .rxdet_start(rxdet_start),
    .attach_ufp(attach_ufp), .attach_dfp(attach_dfp), .resp_dly(resp_dly),
    .rxdet_done(rxdet_done), .term_ufp(term_ufp), .term_dfp(term_dfp));
  // 20 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // Step n edges, then 1 ns
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // One register write, then settle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    cyc(2);
  endtask
  // One register read, compared with e
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
    cyc(1);
    `CHK(reg_rdata, e)
  endtask
  // Reset for 6 cycles with a given mode strap
  task automatic do_reset(input logic [1:0] m);
    rst_n = 1'b0;
    mode_strap = m;
    cyc(6);
    rst_n = 1'b1;
    cyc(3);
  endtask
  // Bounded wait for a link state
  task automatic wait_ls(input urc_link_e e, input int bound);
    for (int i = 0; i < bound && link_state !== e; i++)
      cyc(1);
    `CHK(link_state, e)
    if (link_state !== e)
      give_verdict();
  endtask
  // Single strap level to gain code
  function automatic logic [3:0] dec(input logic [1:0] l);
    return l == LVL_LOW ? GAIN_3DB : l == LVL_RES ? GAIN_6DB :
      l == LVL_FLT ? GAIN_9DB : GAIN_12DB;
  endfunction
  // Expected system-side gain from the straps
  function automatic logic [3:0] sys_exp(input logic p);
    if (eq_config_strap == LVL_HIGH || eq_config_strap == LVL_RES)
      return dec(p ? sys_gain_strap_1 : sys_gain_strap_0);
    return {sys_gain_strap_1, sys_gain_strap_0};
  endfunction
  // Expected connector-side gain from the straps
  function automatic logic [3:0] conn_exp(input logic p);
    if (eq_config_strap == LVL_LOW || eq_config_strap == LVL_RES)
      return dec(p ? conn_gain_strap_1 : conn_gain_strap_0);
    return {conn_gain_strap_1, conn_gain_strap_0};
  endfunction
  // Counts, verdict and end of run
  task automatic give_verdict();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    logic [3:0] e1, e2, c1, c2;
    logic [7:0] v;
    {rst_n, path_en_pin, flip_pin, aeq_pin, reg_wr, reg_rd} = 6'h00;
    {eidle_ufp, eidle_dfp, lfps_valid, chan_long} = 4'h0;
    {attach_ufp, attach_dfp} = 2'h3;
    {mode_strap, eq_config_strap, sys_gain_strap_0} = 6'h00;
    {sys_gain_strap_1, conn_gain_strap_0, conn_gain_strap_1} = 6'h00;
    {reg_addr, reg_wdata, aeq_result, resp_dly} = 24'h000000;
    void'($urandom(41409));
    do_reset(LVL_FLT);
    `CHK(fwd_en, 1'b0)
    rd(OFS_GEN_CTRL, RST_GEN_CTRL);
    rd(OFS_AEQ_CTRL, RST_AEQ_CTRL);
    rd(8'h33, 8'h00);
    $display("reset test done");
    // Strap decode: every config level first, then random
    for (int i = 0; i < 12; i++) begin
      eq_config_strap = i < 4 ? i[1:0] : 2'($urandom);
      {sys_gain_strap_0, sys_gain_strap_1} = 4'($urandom);
      {conn_gain_strap_0, conn_gain_strap_1} = 4'($urandom);
      flip_pin = 1'($urandom);
      do_reset(LVL_HIGH);
      e1 = sys_exp(0);
      e2 = sys_exp(1);
      c1 = conn_exp(0);
      c2 = conn_exp(1);
      sys_gain_strap_0 = ~sys_gain_strap_0;
      conn_gain_strap_1 = ~conn_gain_strap_1;
      wr(OFS_SYS_EQ, 8'h5A);
      `CHK(sys_eq_1, e1)
      `CHK(sys_eq_2, e2)
      `CHK(conn_eq_1, c1)
      `CHK(conn_eq_2, c2)
      `CHK(flip, flip_pin)
    end
    $display("strap test done");
    // Serial register sequences
    do_reset(LVL_FLT);
    v = 8'($urandom);
    wr(OFS_GEN_CTRL, 8'h11);
    wr(OFS_AEQ_CTRL, 8'h80);
    wr(OFS_SWING, 8'hC0);
    wr(OFS_CONN_SHORT, 8'h44);
    wr(OFS_SYS_EQ, v);
    rd(OFS_SYS_EQ, v);
    `CHK({sys_eq_2, sys_eq_1, swing}, {v, 8'hC0})
    `CHK({conn_eq_2, conn_eq_1, aeq_mode}, {8'h44, AEQ_MODE_OFF})
    wr(OFS_TX1_LIM_EQ, 8'h6F);
    wr(OFS_TX2_LIM_EQ, 8'h6C);
    wr(OFS_GEN_CTRL, 8'h15);
    `CHK({flip, limited_mode, tx1_eq}, {2'h2, 8'h00})
    wr(OFS_GEN_CTRL, 8'h95);
    `CHK({flip, limited_mode, tx1_eq, tx2_eq}, 18'h36F6C)
    wr(OFS_GEN_CTRL, 8'h81);
    `CHK({conn_eq_2, conn_eq_1}, {conn_exp(1), conn_exp(0)})
    wr(OFS_GEN_CTRL, 8'h11);
    wr(OFS_AEQ_CTRL, 8'h81);
    wr(OFS_OVER_EQ, 8'h10);
    wr(OFS_CONN_LONG, 8'h77);
    wr(OFS_CONN_SHORT, 8'h11);
    chan_long = 1'b1;
    cyc(3);
    `CHK({conn_eq_1, aeq_mode, over_eq}, {4'h7, AEQ_MODE_FAST, 8'h10})
    chan_long = 1'b0;
    cyc(3);
    `CHK({conn_eq_2, conn_eq_1}, 8'h11)
    wr(OFS_AEQ_CTRL, 8'h85);
    aeq_result = 4'h5;
    cyc(3);
    `CHK({conn_eq_1, aeq_mode, aeq_limit}, {4'h5, AEQ_MODE_FULL, 4'h8})
    aeq_result = 4'hC;
    wr(OFS_CONN_SHORT, 8'h33);
    `CHK({conn_eq_2, conn_eq_1}, 8'h88)
    $display("register test done");
    // Link walk in strap mode
    path_en_pin = 1'b1;
    resp_dly = 4'($urandom);
    do_reset(LVL_HIGH);
    wait_ls(LS_U0, 600);
    `CHK({fwd_en, rx_term_en, tx_cm_hold, rxdet_start}, 4'hE)
    aeq_pin = 1'b1;
    eidle_ufp = 1'b1;
    cyc(5);
    `CHK(link_state, LS_U0)
    `CHK({conn_eq_1, aeq_mode}, {4'hC, AEQ_MODE_FULL})
    eidle_dfp = 1'b1;
    cyc(2);
    `CHK({link_state, fwd_en, rx_term_en, tx_cm_hold}, {LS_U1, 3'h3})
    eidle_ufp = 1'b0;
    cyc(1);
    `CHK(link_state, LS_U0)
    eidle_ufp = 1'b1;
    wait_ls(LS_U23, 260);
    `CHK({rx_term_en, tx_cm_hold}, 2'h2)
    lfps_valid = 1'b1;
    cyc(1);
    lfps_valid = 1'b0;
    `CHK(link_state, LS_U0)
    wait_ls(LS_U23, 300);
    attach_ufp = 1'b0;
    wait_ls(LS_DISC, 600);
    $display("strap link test done");
    // Low power disable and path disable in serial mode
    {eidle_ufp, eidle_dfp, attach_ufp} = 3'h7;
    do_reset(LVL_FLT);
    wr(OFS_GEN_CTRL, 8'h19);
    wait_ls(LS_U0, 600);
    cyc(250);
    `CHK(link_state, LS_U0)
    wr(OFS_GEN_CTRL, 8'h10);
    wait_ls(LS_DISC, 4);
    $display("serial link test done");
    give_verdict();
  end
endmodule // test_usb_redriver_state_and_eq_ctrl
